// ===== rtl/isvm_map.svh
`ifndef ISVM_MAP_SVH
`define ISVM_MAP_SVH

// request lines and level fields
`define ISVM_LINES 24
`define ISVM_LVL_W 2
`define ISVM_LVL_RST 2'h3
`define ISVM_LVL_OFF 2'h3
`define ISVM_FIELDS_PER_REG 4

// vector table: line n high byte at top minus two n
`define ISVM_VEC_TOP 16'hFFFA
`define ISVM_VEC_STEP 16'h0002

// register word indices (byte address = index * 4)
`define ISVM_LVL_REGS 6
`define ISVM_IDX_STAT 6'h06
`define ISVM_IDX_MASK 6'h07
`define ISVM_IDX_LSB 2
`define ISVM_IDX_MSB 7

// source to request line assignment
`define ISVM_LN_EXT4 5'h00
`define ISVM_LN_EXT5 5'h01
`define ISVM_LN_EXT26 5'h02
`define ISVM_LN_EXT37 5'h03
`define ISVM_LN_T0LO 5'h05
`define ISVM_LN_T0HI 5'h06
`define ISVM_LN_URX 5'h07
`define ISVM_LN_UTX 5'h08
`define ISVM_LN_T1HI 5'h0E
`define ISVM_LN_ADC 5'h12
`define ISVM_LN_TBT 5'h13
`define ISVM_LN_WPS 5'h14
`define ISVM_LN_T1LO 5'h16
`define ISVM_LN_FLASH 5'h17

// external interrupt channel bit positions
`define ISVM_EXT2 2
`define ISVM_EXT3 3
`define ISVM_EXT4 4
`define ISVM_EXT5 5
`define ISVM_EXT6 6
`define ISVM_EXT7 7

`endif

// ===== rtl/isvm_pkg.sv
`include "isvm_map.svh"

package isvm_pkg;
	typedef logic [1:0] isvm_level_t;
	typedef logic [4:0] isvm_line_t;
	typedef logic [23:0] isvm_vec24_t;

	function automatic logic [15:0] isvm_vec_addr(input isvm_line_t ln);
		isvm_vec_addr = `ISVM_VEC_TOP - 16'({11'h000, ln} * `ISVM_VEC_STEP);
	endfunction
endpackage

// ===== rtl/isvm_prio.sv
`include "isvm_map.svh"

module isvm_prio (
	input wire logic [23:0] pend,
	input wire logic [1:0] lvl [24],
	input wire logic [1:0] cpuMask,
	output logic found,
	output logic [4:0] line,
	output logic [1:0] level
);
	always_comb begin
		found = 1'b0;
		line = 5'h00;
		level = `ISVM_LVL_OFF;
		// walk downward so an equal level seen later (lower number) wins
		for (int i = `ISVM_LINES - 1; i >= 0; i--) begin
			if (pend[i] && lvl[i] < cpuMask) begin
				if (!found || lvl[i] <= level) begin
					found = 1'b1;
					line = 5'(i);
					level = lvl[i];
				end
			end
		end
	end
endmodule

// ===== rtl/isvm_top.sv
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`include "isvm_map.svh"

module isvm_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	input wire logic [7:0] extIrq,
	input wire logic timer0Lo,
	input wire logic timer0Hi,
	input wire logic timer1Lo,
	input wire logic timer1Hi,
	input wire logic uartRx,
	input wire logic uartTx,
	input wire logic adcIrq,
	input wire logic tbtIrq,
	input wire logic watchIrq,
	input wire logic flashIrq,
	input wire logic [1:0] cpuMask,
	input wire logic cpuAck,
	output logic cpuReq,
	output logic [4:0] cpuLine,
	output logic [1:0] cpuLvl,
	output logic [15:0] cpuVec,
	output logic irq
);
	isvm_pkg::isvm_level_t lvl [24];
	isvm_pkg::isvm_vec24_t pend;
	isvm_pkg::isvm_vec24_t mask;
	isvm_pkg::isvm_vec24_t srcSet;
	logic [5:0] idx;
	logic access;
	logic wrDone;
	logic rdStart;
	logic found;
	logic [4:0] winLine;
	logic [1:0] winLvl;
	logic [23:0] pendClr;
	logic [23:0] setClash;

	assign idx = avsAddress[`ISVM_IDX_MSB:`ISVM_IDX_LSB];
	assign access = avsRead || avsWrite;
	assign wrDone = avsWrite && !avsWaitrequest;
	assign rdStart = avsRead && avsWaitrequest;

	function automatic logic [31:0] lvl_word(input logic [5:0] r);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int k = 0; k < `ISVM_FIELDS_PER_REG; k++) begin
			w[2*k +: 2] = lvl[r * `ISVM_FIELDS_PER_REG + k];
		end
		return w;
	endfunction

	function automatic logic [23:0] be_mask24(input logic [3:0] be);
		be_mask24 = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// peripheral events onto request lines; shared lines are plain ORs
	always_comb begin
		srcSet = 24'h00_0000;
		srcSet[`ISVM_LN_EXT4] = extIrq[`ISVM_EXT4];
		srcSet[`ISVM_LN_EXT5] = extIrq[`ISVM_EXT5];
		srcSet[`ISVM_LN_EXT26] = extIrq[`ISVM_EXT2] | extIrq[`ISVM_EXT6];
		srcSet[`ISVM_LN_EXT37] = extIrq[`ISVM_EXT3] | extIrq[`ISVM_EXT7];
		srcSet[`ISVM_LN_T0LO] = timer0Lo;
		srcSet[`ISVM_LN_T0HI] = timer0Hi;
		srcSet[`ISVM_LN_URX] = uartRx;
		srcSet[`ISVM_LN_UTX] = uartTx;
		srcSet[`ISVM_LN_T1HI] = timer1Hi;
		srcSet[`ISVM_LN_ADC] = adcIrq;
		srcSet[`ISVM_LN_TBT] = tbtIrq;
		srcSet[`ISVM_LN_WPS] = watchIrq;
		srcSet[`ISVM_LN_T1LO] = timer1Lo;
		srcSet[`ISVM_LN_FLASH] = flashIrq;
	end

	// one wait cycle for every access, mapped or not
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avsWaitrequest <= 1'b1;
		end else if (access && avsWaitrequest) begin
			avsWaitrequest <= 1'b0;
		end else begin
			avsWaitrequest <= 1'b1;
		end
	end

	// unmapped words read as zero, which is one legal undefined value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avsReaddata <= 32'h0000_0000;
		end else if (rdStart) begin
			if (idx < 6'(`ISVM_LVL_REGS)) begin
				avsReaddata <= lvl_word(idx);
			end else if (idx == `ISVM_IDX_STAT) begin
				avsReaddata <= {8'h00, pend};
			end else if (idx == `ISVM_IDX_MASK) begin
				avsReaddata <= {8'h00, mask};
			end else begin
				avsReaddata <= 32'h0000_0000;
			end
		end
	end

	// level fields, four to a word in byte lane zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `ISVM_LINES; i++) begin
				lvl[i] <= `ISVM_LVL_RST;
			end
		end else if (wrDone && avsByteenable[0]) begin
			for (int r = 0; r < `ISVM_LVL_REGS; r++) begin
				if (idx == 6'(r)) begin
					for (int k = 0; k < `ISVM_FIELDS_PER_REG; k++) begin
						lvl[r * `ISVM_FIELDS_PER_REG + k] <=
							avsWritedata[2*k +: 2];
					end
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask <= 24'h00_0000;
		end else if (wrDone && idx == `ISVM_IDX_MASK) begin
			mask <= (mask & ~be_mask24(avsByteenable)) |
				(avsWritedata[23:0] & be_mask24(avsByteenable));
		end
	end

	// sticky pending: write-one or core acknowledge clears, a new event wins
	always_comb begin
		pendClr = 24'h00_0000;
		if (wrDone && idx == `ISVM_IDX_STAT) begin
			pendClr = avsWritedata[23:0] & be_mask24(avsByteenable);
		end
		if (cpuReq && cpuAck) begin
			pendClr[cpuLine] = 1'b1;
		end
	end

	// events that land on a line in its clearing cycle; kept, never lost
	assign setClash = srcSet & pendClr;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend <= 24'h00_0000;
		end else begin
			pend <= (pend & ~pendClr) | srcSet;
		end
	end

	isvm_prio isvm_prio_inst (
		.pend(pend),
		.lvl(lvl),
		.cpuMask(cpuMask),
		.found(found),
		.line(winLine),
		.level(winLvl)
	);

	// the acknowledged line is masked for one cycle so it is not re-offered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpuReq <= 1'b0;
			cpuLine <= 5'h00;
			cpuLvl <= `ISVM_LVL_OFF;
			cpuVec <= `ISVM_VEC_TOP;
		end else begin
			cpuReq <= found && !(cpuReq && cpuAck && winLine == cpuLine);
			cpuLine <= winLine;
			cpuLvl <= winLvl;
			cpuVec <= isvm_pkg::isvm_vec_addr(winLine);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(pend & mask);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_LVL_WRITE: assert property (
		(wrDone && avsByteenable[0] && idx == 6'h00)
		|=> (lvl[0] == $past(avsWritedata[1:0]) &&
			lvl[3] == $past(avsWritedata[7:6])))
		else $error("level field write not stored");

	AST_LVL_WRITE_TOP: assert property (
		(wrDone && avsByteenable[0] && idx == 6'h05)
		|=> (lvl[22] == $past(avsWritedata[5:4]) &&
			lvl[23] == $past(avsWritedata[7:6])))
		else $error("top level register write not stored");

	AST_LVL_READ: assert property (
		(rdStart && idx == 6'h00)
		|=> (avsReaddata[7:0] == {$past(lvl[3]), $past(lvl[2]),
			$past(lvl[1]), $past(lvl[0])}))
		else $error("level register read back wrong");

	// level zero is the top, so nothing else can outrank this pair
	AST_TIE_LOWEST: assert property (
		(pend[0] && pend[1] && lvl[0] == 2'h0 && lvl[1] == 2'h0
			&& cpuMask != 2'h0 && !(cpuReq && cpuAck))
		|=> (cpuReq && cpuLine == 5'h00))
		else $error("equal level tie not won by lowest line");

	AST_TIE_TWO: assert property (
		(pend[2] && pend[3] && !pend[0] && !pend[1] && lvl[2] == 2'h0
			&& lvl[3] == 2'h0 && cpuMask != 2'h0 && !(cpuReq && cpuAck))
		|=> (cpuReq && cpuLine == 5'h02))
		else $error("line 2 did not win its tie with line 3");

	AST_ACK_CLEARS: assert property (
		(cpuReq && cpuAck && !srcSet[cpuLine]) |=> !pend[$past(cpuLine)])
		else $error("acknowledged line still pending");

	AST_SET_WINS: assert property (
		(|setClash) |=> ((pend & $past(setClash)) == $past(setClash)))
		else $error("new event lost to a same-cycle clear");

	AST_STAT_READ: assert property (
		(rdStart && idx == `ISVM_IDX_STAT)
		|=> (avsReaddata[23:0] == $past(pend)))
		else $error("status read does not show pending lines");

	AST_WIN_VALID: assert property (
		cpuReq |-> cpuLine < 5'(`ISVM_LINES))
		else $error("offered line number out of range");

	AST_SHARE_TWO: assert property (
		(extIrq[`ISVM_EXT6] || extIrq[`ISVM_EXT2])
		|=> pend[`ISVM_LN_EXT26])
		else $error("channel two or six did not raise line 2");

	AST_SHARE_THREE: assert property (
		(extIrq[`ISVM_EXT7] || extIrq[`ISVM_EXT3])
		|=> pend[`ISVM_LN_EXT37])
		else $error("channel three or seven did not raise line 3");

	AST_T0_LOW: assert property (
		timer0Lo |=> pend[`ISVM_LN_T0LO])
		else $error("timer zero lower half did not raise line 5");

	AST_T0_HIGH: assert property (
		timer0Hi |=> pend[`ISVM_LN_T0HI])
		else $error("timer zero upper half did not raise line 6");

	AST_T1_HALVES: assert property (
		(timer1Hi || timer1Lo)
		|=> ((pend[`ISVM_LN_T1HI] || !$past(timer1Hi)) &&
			(pend[`ISVM_LN_T1LO] || !$past(timer1Lo))))
		else $error("timer one halves mapped to wrong lines");

	AST_VECTOR: assert property (
		cpuReq |-> (cpuVec + {10'h000, cpuLine, 1'b0}) == `ISVM_VEC_TOP)
		else $error("vector address does not match line");

	AST_LEVEL_GATE: assert property (
		cpuReq |-> cpuLvl < $past(cpuMask))
		else $error("request forwarded at a level the core masks");

	AST_MASK_ZERO: assert property (
		(cpuMask == 2'h0) |=> !cpuReq)
		else $error("request offered while the core masks all levels");

	AST_LVL_RANGE: assert property (
		cpuReq |-> cpuLvl != `ISVM_LVL_OFF)
		else $error("disabled level offered to the core");

	AST_ANSWER: assert property (
		(access && avsWaitrequest) |=> !avsWaitrequest ##1 avsWaitrequest)
		else $error("access not answered in one wait cycle");

	COV_TIE: cover property (cpuReq && cpuAck ##1 cpuReq);
	COV_SHARED: cover property (extIrq[`ISVM_EXT6] ##2 cpuReq);
	COV_IRQ: cover property (!irq ##1 irq);
	COV_EQUAL: cover property (cpuReq && cpuLine == 5'h00
		##[1:8] cpuReq && cpuLine == 5'h01);
	COV_CLASH: cover property (|setClash);
endmodule

// ===== sim/isvm_core_model.sv
module isvm_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic cpuReq,
	input wire logic slow,
	output logic cpuAck
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] gap;
	// one ack per offer; the gap lets the next winner settle first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpuAck <= 1'b0;
			gap <= 3'h0;
		end else if (cpuAck) begin
			cpuAck <= 1'b0;
			gap <= slow ? 3'h6 : 3'h2;
		end else if (gap != 3'h0) begin
			gap <= gap - 3'h1;
		end else begin
			cpuAck <= cpuReq;
		end
	end
endmodule

// ===== sim/isvm_tb_top.sv
module isvm_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, avsRead, avsWrite, avsWaitrequest, irq, cpuReq;
	logic cpuAck, slow;
	logic [7:0] avsAddress, r;
	logic [31:0] avsWritedata, avsReaddata, rd;
	logic [3:0] avsByteenable;
	logic [1:0] cpuMask, cpuLvl;
	logic [4:0] cpuLine;
	logic [15:0] cpuVec;
	logic [17:0] src;
	logic [22:0] expQ[$];
	logic [4:0] order[6] = '{5'h0E, 5'h16, 5'h05, 5'h06, 5'h02, 5'h03};
	logic [1:0] olvl[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	isvm_top isvm_top_inst (.clk(clk), .rst(rst), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
		.avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest), .extIrq(src[17:10]),
		.timer0Lo(src[9]), .timer0Hi(src[8]), .timer1Lo(src[7]),
		.timer1Hi(src[6]), .uartRx(src[5]), .uartTx(src[4]),
		.adcIrq(src[3]), .tbtIrq(src[2]), .watchIrq(src[1]),
		.flashIrq(src[0]), .cpuMask(cpuMask), .cpuAck(cpuAck),
		.cpuReq(cpuReq), .cpuLine(cpuLine), .cpuLvl(cpuLvl),
		.cpuVec(cpuVec), .irq(irq));
	isvm_core_model isvm_core_model_inst (.clk(clk), .rst(rst),
		.cpuReq(cpuReq), .slow(slow), .cpuAck(cpuAck));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic bus(input logic [7:0] a, input logic wr,
		input logic [31:0] d);
		@(posedge clk);
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= ~wr;
		avsWritedata <= d;
		// only the bench timeout ends a wait that never answers
		do begin
			@(posedge clk);
		end while (avsWaitrequest !== 1'b0);
		rd = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask

	task automatic pulse(input logic [17:0] s);
		@(posedge clk);
		src <= s;
		@(posedge clk);
		src <= 18'h0;
	endtask

	task automatic note(input logic [4:0] ln, input logic [1:0] lv);
		expQ.push_back({lv, ln, 16'hFFFA - 16'(ln) * 16'h0002});
	endtask

	task automatic drain;
		for (int n = 0; n < 200 && expQ.size() != 0; n++)
			@(posedge clk);
		check(expQ.size(), 0);
	endtask

	// every accepted vector is compared with the oldest expectation
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run;
		end else if (cpuReq === 1'b1 && cpuAck === 1'b1) begin
			if (expQ.size() == 0)
				check(32'h1, 32'h0);
			else
				check({cpuLvl, cpuLine, cpuVec}, expQ.pop_front());
		end
	end

	initial begin
		rst = 1'b1;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsAddress = 8'h00;
		avsWritedata = 32'h0;
		avsByteenable = 4'hF;
		src = 18'h0;
		cpuMask = 2'h0;
		slow = 1'b0;
		r = 8'h4C;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		bus(8'h00, 1'b0, 32'h0);
		check(rd, 32'h0000_00FF);
		// data of an unused word is left unchecked
		bus(8'h40, 1'b0, 32'h0);
		cpuMask <= 2'h3;
		// levels: 4, 14 and 22 at 0, 5 and 6 at 1, 2 and 3 at 2, rest 3
		// writes go to mapped words only
		bus(8'h00, 1'b1, 32'h0000_00AF);
		bus(8'h04, 1'b1, 32'h0000_00D4);
		bus(8'h0C, 1'b1, 32'h0000_00CF);
		bus(8'h14, 1'b1, 32'h0000_00CF);
		foreach (order[i])
			note(order[i], olvl[i]);
		pulse(18'h303FF);
		drain;
		// equal levels on lines 0..3, random channel mix
		bus(8'h00, 1'b1, 32'h0);
		repeat (6) begin
			r = lfsr(r);
			slow <= r[0];
			if (r[4]) note(5'h00, 2'h0);
			if (r[5]) note(5'h01, 2'h0);
			if (r[2] | r[6]) note(5'h02, 2'h0);
			if (r[3] | r[7]) note(5'h03, 2'h0);
			pulse({r & 8'hFC, 10'h0});
			drain;
		end
		cpuMask <= 2'h0;
		bus(8'h1C, 1'b1, 32'h0008_0000);
		pulse(18'h00004);
		repeat (3) @(posedge clk);
		check(irq, 1'b1);
		check(cpuReq, 1'b0);
		// level-3 lines stay pending unoffered
		bus(8'h18, 1'b0, 32'h0);
		check(rd, 32'h009C_0180);
		bus(8'h18, 1'b1, 32'h009C_0180);
		repeat (3) @(posedge clk);
		check(irq, 1'b0);
		complete_run;
	end
endmodule
